// ==== pkg/cts_pkg.sv ====
// Purpose: Constants for the control timer set bits and synchronisation busy flags.
// Assumes: AHB-Lite word access, one clock, prescaled timer tick made inside the block.
// Notes: Offsets are register indices; byte address is four times the index.
package cts_pkg;
   // ----------------------------------------------------------------
   // Register indices
   // ----------------------------------------------------------------
   localparam logic [7:0] CTS_IDX_CTRLA = 8'h00;
   localparam logic [7:0] CTS_IDX_CLR = 8'h04;
   localparam logic [7:0] CTS_IDX_SET = 8'h05;
   localparam logic [7:0] CTS_IDX_BUSY = 8'h08;
   localparam logic [7:0] CTS_IDX_STATUS = 8'h10;
   localparam logic [7:0] CTS_IDX_COUNT = 8'h11;
   localparam logic [7:0] CTS_IDX_WAVE = 8'h12;
   localparam logic [7:0] CTS_IDX_OVR = 8'h13;
   localparam logic [7:0] CTS_IDX_LEN = 8'h14;
   localparam logic [7:0] CTS_IDX_CMP0 = 8'h15;
   localparam logic [7:0] CTS_IDX_SHAPEB = 8'h1A;
   localparam logic [7:0] CTS_IDX_OVRB = 8'h1B;
   localparam logic [7:0] CTS_IDX_LENB = 8'h1C;
   localparam logic [7:0] CTS_IDX_CMPB0 = 8'h1D;
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CTS_B_DIR = 0;
   localparam int CTS_B_LOCK = 1;
   localparam int CTS_B_SINGLE = 2;
   localparam int CTS_B_SRST = 0;
   localparam int CTS_B_ENABLE = 1;
   localparam int CTS_B_CAPT = 2;
   localparam int CTS_B_STOP = 0;
   localparam int CTS_S_SRST = 0;
   localparam int CTS_S_ENABLE = 1;
   localparam int CTS_S_CTL2 = 2;
   localparam int CTS_S_STATUS = 3;
   localparam int CTS_S_COUNT = 4;
   localparam int CTS_S_OVR = 5;
   localparam int CTS_S_WAVE = 6;
   localparam int CTS_S_LEN = 7;
   localparam int CTS_S_CMP0 = 8;
   localparam int CTS_S_OVRB = 16;
   localparam int CTS_S_SHAPEB = 17;
   localparam int CTS_S_LENB = 18;
   localparam int CTS_S_CMPB0 = 19;
   // ----------------------------------------------------------------
   // Sizes, reset values and timing
   // ----------------------------------------------------------------
   localparam int CTS_CH = 4;
   localparam int CTS_W = 16;
   localparam logic [3:0] CTS_CH_PRESENT = 4'hF;
   localparam logic [31:0] CTS_BUSY_RST = 32'h0000_0000;
   localparam logic [15:0] CTS_LEN_RST = 16'hFFFF;
   localparam logic [15:0] CTS_ZERO16 = 16'h0000;
   localparam logic [15:0] CTS_ONE16 = 16'h0001;
   localparam logic [7:0] CTS_ZERO8 = 8'h00;
   localparam logic [2:0] CTS_ZERO3 = 3'h0;
   localparam logic [31:0] CTS_ZERO32 = 32'h0000_0000;
   localparam logic [1:0] CTS_PRESC_MAX = 2'h3;
   localparam logic [1:0] CTS_PRESC_ONE = 2'h1;
   localparam logic [1:0] CTS_PRESC_RST = 2'h0;
endpackage

// ==== logic/cts_top.sv ====
// Purpose: Control timer set bits, counter core and synchronisation busy register.
// Assumes: Single AHB-Lite master, word transfers only, timer ticks every fourth clock.
// Notes: Soft reset clears control state only once its crossing completes.
// Functional notes
// - Writing one to single_run in the set register enables it; zero does nothing.
// - With single_run on, counting stops at next overflow or underflow.
// - With single_run off, the counter wraps and keeps running.
// - Writing one to buffer_transfer_lock in the set register locks updates.
// - Unlocked update copies compare, period, pattern and waveform buffers to active.
// - Locked update transfers no buffered value.
// - Lock is ignored while input capture is enabled.
// - Writing one to direction in the set register clears it; zero ignored.
// - Direction zero counts up, one counts down.
// - Busy bits 19 to 22 track compare buffer channel crossings.
// - Channel busy flags exist only for present channels.
// - Busy 18 period buffer, 17 waveform buffer, 16 pattern buffer.
// - Busy bits 8 to 11 track active compare channel crossings.
// - Busy 7 period, 6 waveform, 5 pattern register.
// - Busy 4 tracks the counter value crossing.
// - Busy 3 status, 2 second control, 1 enable.
// - Busy 0 tracks the soft reset crossing.
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/1ps
module cts_top
   import cts_pkg::*;
(
   // Clock and reset
   input wire logic CLK_I,
   input wire logic RESET_N_I,
   // AHB-Lite slave
   input wire logic HSEL_I,
   input wire logic [31:0] HADDR_I,
   input wire logic [1:0] HTRANS_I,
   input wire logic HWRITE_I,
   input wire logic [2:0] HSIZE_I,
   input wire logic [31:0] HWDATA_I,
   input wire logic HREADY_I,
   output logic [31:0] HRDATA_O,
   output logic HREADYOUT_O,
   output logic HRESP_O,
   // Timer state
   output logic [15:0] COUNT_O,
   output logic RUNNING_O,
   output logic UPDATE_O
);
   // ----------------------------------------------------------------
   // Bus address phase
   // ----------------------------------------------------------------
   logic wr_pend;
   logic [7:0] wr_idx;
   logic [31:0] busy;
   logic [31:0] staged;
   logic [1:0] presc;
   logic single_run;
   logic buffer_transfer_lock;
   logic dir;
   logic enable;
   logic capture_en;
   logic stopped;
   logic [15:0] count;
   logic [15:0] cycle_length;
   logic [15:0] cycle_length_buffer;
   logic [7:0] output_shape;
   logic [7:0] output_shape_buffer;
   logic [15:0] pin_override;
   logic [15:0] pin_override_buffer;
   logic [15:0] compare_capture_reg [CTS_CH];
   logic [15:0] cmp_buffer_reg [CTS_CH];

   wire addr_ok = HSEL_I & HTRANS_I[1] & HREADY_I;
   wire [7:0] a_idx = HADDR_I[9:2];
   wire wr = wr_pend;
   wire [31:0] wd = HWDATA_I;

   function automatic logic hit(input logic [7:0] i, input logic [7:0] r);
      hit = (i == r);
   endfunction

   function automatic logic ch_hit(input logic [7:0] i, input logic [7:0] base, input int c);
      ch_hit = (i == (base + 8'(c)));
   endfunction

   // ----------------------------------------------------------------
   // Timer tick and synchronisation handshake
   // ----------------------------------------------------------------
   wire tick = (presc == CTS_PRESC_MAX);
   wire [31:0] done = tick ? staged : CTS_ZERO32;
   wire srst_done = done[CTS_S_SRST];
   // Bits 12 to 15 and 23 upwards are reserved, so they can never be set.
   wire [31:0] ch_mask = {9'h000, CTS_CH_PRESENT, 3'h7, 4'h0, CTS_CH_PRESENT, 8'hFF};

   logic [31:0] set_mask;
   always_comb begin
      set_mask = CTS_ZERO32;
      if (wr) begin
         set_mask[CTS_S_SRST] = hit(wr_idx, CTS_IDX_CTRLA) & wd[CTS_B_SRST];
         set_mask[CTS_S_ENABLE] = hit(wr_idx, CTS_IDX_CTRLA);
         set_mask[CTS_S_CTL2] = hit(wr_idx, CTS_IDX_CLR) | hit(wr_idx, CTS_IDX_SET);
         set_mask[CTS_S_STATUS] = hit(wr_idx, CTS_IDX_STATUS);
         set_mask[CTS_S_COUNT] = hit(wr_idx, CTS_IDX_COUNT);
         set_mask[CTS_S_OVR] = hit(wr_idx, CTS_IDX_OVR);
         set_mask[CTS_S_WAVE] = hit(wr_idx, CTS_IDX_WAVE);
         set_mask[CTS_S_LEN] = hit(wr_idx, CTS_IDX_LEN);
         set_mask[CTS_S_OVRB] = hit(wr_idx, CTS_IDX_OVRB);
         set_mask[CTS_S_SHAPEB] = hit(wr_idx, CTS_IDX_SHAPEB);
         set_mask[CTS_S_LENB] = hit(wr_idx, CTS_IDX_LENB);
         for (int c = 0; c < CTS_CH; c++) begin
            set_mask[CTS_S_CMP0 + c] = ch_hit(wr_idx, CTS_IDX_CMP0, c);
            set_mask[CTS_S_CMPB0 + c] = ch_hit(wr_idx, CTS_IDX_CMPB0, c);
         end
         set_mask = set_mask & ch_mask;
      end
   end

   // A new write wins over a completing crossing, so a rewrite restarts it.
   wire [31:0] next_busy = (busy & ~done) | set_mask;
   wire [31:0] next_staged = tick ? (busy & ~staged & ~set_mask) : (staged & ~set_mask);

   // ----------------------------------------------------------------
   // Counter core
   // ----------------------------------------------------------------
   wire run = enable & ~stopped;
   wire wrap_up = ~dir & (count == cycle_length);
   wire wrap_dn = dir & (count == CTS_ZERO16);
   wire wrap = run & tick & (wrap_up | wrap_dn);
   wire do_update = wrap & (~buffer_transfer_lock | capture_en);
   wire [15:0] next_count = wrap_up ? CTS_ZERO16 :
                            wrap_dn ? cycle_length :
                            dir ? (count - CTS_ONE16) : (count + CTS_ONE16);
   wire wr_clr = wr & hit(wr_idx, CTS_IDX_CLR);
   wire wr_set = wr & hit(wr_idx, CTS_IDX_SET);

   // ----------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------
   wire [7:0] ctl2_val = {5'h00, single_run, buffer_transfer_lock, dir};
   logic [31:0] rd_val;
   always_comb begin
      rd_val = CTS_ZERO32;
      if (hit(a_idx, CTS_IDX_CTRLA)) begin
         rd_val = {29'h0, capture_en, enable, busy[CTS_S_SRST]};
      end
      if (hit(a_idx, CTS_IDX_CLR) | hit(a_idx, CTS_IDX_SET)) begin
         rd_val = {24'h0, ctl2_val};
      end
      if (hit(a_idx, CTS_IDX_BUSY)) begin
         rd_val = busy;
      end
      if (hit(a_idx, CTS_IDX_STATUS)) begin
         rd_val = {31'h0, stopped};
      end
      if (hit(a_idx, CTS_IDX_COUNT)) begin
         rd_val = {16'h0, count};
      end
      if (hit(a_idx, CTS_IDX_WAVE)) begin
         rd_val = {24'h0, output_shape};
      end
      if (hit(a_idx, CTS_IDX_SHAPEB)) begin
         rd_val = {24'h0, output_shape_buffer};
      end
      if (hit(a_idx, CTS_IDX_OVR)) begin
         rd_val = {16'h0, pin_override};
      end
      if (hit(a_idx, CTS_IDX_OVRB)) begin
         rd_val = {16'h0, pin_override_buffer};
      end
      if (hit(a_idx, CTS_IDX_LEN)) begin
         rd_val = {16'h0, cycle_length};
      end
      if (hit(a_idx, CTS_IDX_LENB)) begin
         rd_val = {16'h0, cycle_length_buffer};
      end
      for (int c = 0; c < CTS_CH; c++) begin
         if (ch_hit(a_idx, CTS_IDX_CMP0, c)) begin
            rd_val = {16'h0, compare_capture_reg[c]};
         end
         if (ch_hit(a_idx, CTS_IDX_CMPB0, c)) begin
            rd_val = {16'h0, cmp_buffer_reg[c]};
         end
      end
   end

   assign HREADYOUT_O = 1'b1;
   assign HRESP_O = 1'b0;
   assign COUNT_O = count;
   assign RUNNING_O = run;

   // ----------------------------------------------------------------
   // Bus and handshake registers
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         wr_pend <= 1'b0;
         wr_idx <= CTS_ZERO8;
         HRDATA_O <= CTS_ZERO32;
         presc <= CTS_PRESC_RST;
         busy <= CTS_BUSY_RST;
         staged <= CTS_BUSY_RST;
      end else begin
         wr_pend <= addr_ok & HWRITE_I;
         wr_idx <= a_idx;
         HRDATA_O <= (addr_ok & ~HWRITE_I) ? rd_val : HRDATA_O;
         presc <= presc + CTS_PRESC_ONE;
         busy <= next_busy;
         staged <= next_staged;
      end
   end

   // ----------------------------------------------------------------
   // Control and timer registers
   // ----------------------------------------------------------------
   // The soft reset takes effect only when its crossing completes.
   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         single_run <= 1'b0;
         buffer_transfer_lock <= 1'b0;
         dir <= 1'b0;
         enable <= 1'b0;
         capture_en <= 1'b0;
         stopped <= 1'b0;
         count <= CTS_ZERO16;
         cycle_length <= CTS_LEN_RST;
         cycle_length_buffer <= CTS_LEN_RST;
         output_shape <= CTS_ZERO8;
         output_shape_buffer <= CTS_ZERO8;
         pin_override <= CTS_ZERO16;
         pin_override_buffer <= CTS_ZERO16;
         UPDATE_O <= 1'b0;
         for (int c = 0; c < CTS_CH; c++) begin
            compare_capture_reg[c] <= CTS_ZERO16;
            cmp_buffer_reg[c] <= CTS_ZERO16;
         end
      end else if (srst_done) begin
         // Kept synchronous so that the pin reset stays the only asynchronous path.
         single_run <= 1'b0;
         buffer_transfer_lock <= 1'b0;
         dir <= 1'b0;
         enable <= 1'b0;
         capture_en <= 1'b0;
         stopped <= 1'b0;
         count <= CTS_ZERO16;
         cycle_length <= CTS_LEN_RST;
         cycle_length_buffer <= CTS_LEN_RST;
         output_shape <= CTS_ZERO8;
         output_shape_buffer <= CTS_ZERO8;
         pin_override <= CTS_ZERO16;
         pin_override_buffer <= CTS_ZERO16;
         UPDATE_O <= 1'b0;
         for (int c = 0; c < CTS_CH; c++) begin
            compare_capture_reg[c] <= CTS_ZERO16;
            cmp_buffer_reg[c] <= CTS_ZERO16;
         end
      end else begin
         UPDATE_O <= do_update;
         if (wr_set && wd[CTS_B_SINGLE]) begin
            single_run <= 1'b1;
         end else if (wr_clr && wd[CTS_B_SINGLE]) begin
            single_run <= 1'b0;
         end
         if (wr_set && wd[CTS_B_LOCK]) begin
            buffer_transfer_lock <= 1'b1;
         end else if (wr_clr && wd[CTS_B_LOCK]) begin
            buffer_transfer_lock <= 1'b0;
         end
         if (wr_set && wd[CTS_B_DIR]) begin
            dir <= 1'b0;
         end else if (wr_clr && wd[CTS_B_DIR]) begin
            dir <= 1'b1;
         end
         if (wr && hit(wr_idx, CTS_IDX_CTRLA)) begin
            enable <= wd[CTS_B_ENABLE];
            capture_en <= wd[CTS_B_CAPT];
         end
         if (wrap && single_run) begin
            stopped <= 1'b1;
         end else if (wr && hit(wr_idx, CTS_IDX_STATUS) && wd[CTS_B_STOP]) begin
            stopped <= 1'b0;
         end
         if (wr && hit(wr_idx, CTS_IDX_COUNT)) begin
            count <= wd[15:0];
         end else if (run && tick && !(wrap && single_run)) begin
            count <= next_count;
         end
         if (wr && hit(wr_idx, CTS_IDX_LEN)) begin
            cycle_length <= wd[15:0];
         end else if (do_update) begin
            cycle_length <= cycle_length_buffer;
         end
         if (wr && hit(wr_idx, CTS_IDX_LENB)) begin
            cycle_length_buffer <= wd[15:0];
         end
         if (wr && hit(wr_idx, CTS_IDX_WAVE)) begin
            output_shape <= wd[7:0];
         end else if (do_update) begin
            output_shape <= output_shape_buffer;
         end
         if (wr && hit(wr_idx, CTS_IDX_SHAPEB)) begin
            output_shape_buffer <= wd[7:0];
         end
         if (wr && hit(wr_idx, CTS_IDX_OVR)) begin
            pin_override <= wd[15:0];
         end else if (do_update) begin
            pin_override <= pin_override_buffer;
         end
         if (wr && hit(wr_idx, CTS_IDX_OVRB)) begin
            pin_override_buffer <= wd[15:0];
         end
         for (int c = 0; c < CTS_CH; c++) begin
            if (wr && ch_hit(wr_idx, CTS_IDX_CMP0, c)) begin
               compare_capture_reg[c] <= wd[15:0];
            end else if (do_update) begin
               compare_capture_reg[c] <= cmp_buffer_reg[c];
            end
            if (wr && ch_hit(wr_idx, CTS_IDX_CMPB0, c)) begin
               cmp_buffer_reg[c] <= wd[15:0];
            end
         end
      end
   end
endmodule

// ==== sim/cts_monitor.sv ====
// Purpose: Port checker for the control timer set bits and busy flags.
// Assumes: Zero wait-state bus slave and one clock.
// Notes: Counter step checks skip the cycle in which a bus write lands.
`timescale 1ns/1ps
module cts_monitor
   import cts_pkg::*;
(
   // Clock and reset
   input wire logic CLK_I,
   input wire logic RESET_N_I,
   // Bus
   input wire logic HSEL_I,
   input wire logic [31:0] HADDR_I,
   input wire logic [1:0] HTRANS_I,
   input wire logic HWRITE_I,
   input wire logic HREADY_I,
   input wire logic [31:0] HRDATA_O,
   input wire logic HREADYOUT_O,
   input wire logic HRESP_O,
   // Timer
   input wire logic [15:0] COUNT_O,
   input wire logic RUNNING_O,
   input wire logic UPDATE_O
);
   // A direct write may move the counter, so it is excluded from the steps.
   logic wr_dp;
   wire take = HSEL_I & HTRANS_I[1] & HREADY_I;
   wire rd_at = take & ~HWRITE_I;
   wire [7:0] idx = HADDR_I[9:2];
   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) wr_dp <= 1'b0;
      else wr_dp <= take & HWRITE_I;
   end
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RESET_N_I);
   property p_step;
      $changed(COUNT_O) && !$past(wr_dp) && $past(COUNT_O) != 16'h0000 |->
         COUNT_O == $past(COUNT_O) + 16'h0001 || COUNT_O == $past(COUNT_O) - 16'h0001
         || COUNT_O == 16'h0000;
   endproperty
   a_step: assert property (p_step) else $error("counter jumped");
   property p_gap;
      $changed(COUNT_O) && !$past(wr_dp) |=> ($stable(COUNT_O) || $past(wr_dp)) [*3];
   endproperty
   a_gap: assert property (p_gap) else $error("counter ticked too soon");
   property p_hold;
      !RUNNING_O && !wr_dp |=> $stable(COUNT_O);
   endproperty
   a_hold: assert property (p_hold) else $error("stopped counter moved");
   property p_upd;
      UPDATE_O |=> !UPDATE_O [*3];
   endproperty
   a_upd: assert property (p_upd) else $error("update pulse too long");
   property p_upd_run;
      UPDATE_O |-> $past(RUNNING_O);
   endproperty
   a_upd_run: assert property (p_upd_run) else $error("update while idle");
   property p_rsvd;
      rd_at && idx == CTS_IDX_BUSY |=> HRDATA_O[31:23] == 9'h000 && HRDATA_O[15:12] == 4'h0;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved busy bits set");
   property p_ctrl;
      rd_at && (idx == CTS_IDX_SET || idx == CTS_IDX_CLR) |=> HRDATA_O[31:3] == 29'h0;
   endproperty
   a_ctrl: assert property (p_ctrl) else $error("control read too wide");
   property p_ready;
      1'b1 |-> HREADYOUT_O && !HRESP_O;
   endproperty
   a_ready: assert property (p_ready) else $error("bus stalled or erred");
endmodule
bind cts_top cts_monitor i_mon (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .HSEL_I(HSEL_I),
   .HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HREADY_I(HREADY_I),
   .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O),
   .COUNT_O(COUNT_O), .RUNNING_O(RUNNING_O), .UPDATE_O(UPDATE_O));

// ==== sim/cts_test.sv ====
// Purpose: Register-level bench for the control timer block.
// Assumes: Zero wait-state bus slave, one clock.
// Notes: Short periods keep every wrap within a few dozen clocks.
`timescale 1ns/1ps
module cts_test;
   import cts_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, rdata;
   logic hready, hresp, running, update;
   logic [15:0] count;
   int num_errors = 0;
   int n_checks = 0;
   int n_upd = 0;
   int u0;
   logic [7:0] at [17] = '{8'h14, 8'h40, 8'h44, 8'h4C, 8'h48, 8'h50, 8'h54, 8'h58, 8'h5C,
      8'h60, 8'h6C, 8'h68, 8'h70, 8'h74, 8'h78, 8'h7C, 8'h80};
   int bt [17] = '{2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 16, 17, 18, 19, 20, 21, 22};
   cts_top i_dut (.CLK_I(clk), .RESET_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr),
      .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata),
      .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
      .COUNT_O(count), .RUNNING_O(running), .UPDATE_O(update));
   initial begin
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      if (update === 1'b1) n_upd++;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wait_rdy();
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
   endtask
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      hsize <= 3'h2;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      rdata = hrdata;
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(rdata, exp);
   endtask
   // Software must see the flags clear before trusting a written value.
   task automatic poll_idle();
      int n;
      n = 0;
      do begin
         xfer(1'b0, 32'h20, 32'h0);
         n++;
      end while (rdata !== 32'h0 && n < 8);
      chk(rdata, 32'h0);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge clk);
      num_errors++;
      tally_and_finish();
   end
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      rd(32'h20, 32'h0);
      rd(32'hC0, 32'h0);
      wr(32'h14, 32'h6);
      poll_idle();
      wr(32'h0, 32'h1);
      xfer(1'b0, 32'h20, 32'h0);
      chk(rdata & 32'h1, 32'h1);
      poll_idle();
      rd(32'h14, 32'h0);
      for (int i = 0; i < 17; i++) begin
         wr({24'h0, at[i]}, 32'h0);
         rd(32'h20, 32'h1 << bt[i]);
         poll_idle();
      end
      wr(32'h50, 32'h5);
      for (int d = 0; d < 2; d++) begin
         wr(32'h0, 32'h0);
         wr(32'h44, 32'h3);
         wr(d ? 32'h10 : 32'h14, 32'h1);
         wr(32'h14, 32'h0);
         rd(32'h14, 32'(d));
         wr(32'h0, 32'h2);
         for (int i = 0; i < 20 && count === 16'h3; i++) @(posedge clk);
         chk({16'h0, count}, d ? 32'h2 : 32'h4);
      end
      wr(32'h14, 32'h2);
      rd(32'h14, 32'h3);
      wr(32'h70, 32'h9);
      u0 = n_upd;
      repeat (60) @(posedge clk);
      chk(32'(n_upd - u0), 32'h0);
      rd(32'h50, 32'h5);
      chk({31'h0, running}, 32'h1);
      wr(32'h0, 32'h6);
      repeat (60) @(posedge clk);
      rd(32'h50, 32'h9);
      wr(32'h0, 32'h2);
      wr(32'h10, 32'h2);
      wr(32'h70, 32'h7);
      u0 = n_upd;
      repeat (60) @(posedge clk);
      chk({31'h0, n_upd > u0}, 32'h1);
      rd(32'h50, 32'h7);
      wr(32'h14, 32'h1);
      wr(32'h14, 32'h4);
      rd(32'h14, 32'h4);
      for (int i = 0; i < 100 && running === 1'b1; i++) @(posedge clk);
      chk({31'h0, running}, 32'h0);
      chk({16'h0, count}, 32'h7);
      rd(32'h40, 32'h1);
      wr(32'h10, 32'h4);
      wr(32'h40, 32'h1);
      repeat (12) @(posedge clk);
      chk({31'h0, running}, 32'h1);
      tally_and_finish();
   end
endmodule
